// >>> hdl/smbt_consts.svh
/*
  Constants of the SMBus indexed-block target: addresses, offsets,
  reset values. Assumes inclusion by bare name in the design files.
*/
`ifndef SMBT_CONSTS_SVH
`define SMBT_CONSTS_SVH

// ----------------------------------------------------------------
// target addresses chosen by the latched strap
// ----------------------------------------------------------------
`define SMBT_ADDR_STRAP0 7'h68
`define SMBT_ADDR_STRAP1 7'h6A

// ----------------------------------------------------------------
// config space offsets and values
// ----------------------------------------------------------------
`define SMBT_OFFS_RSVD 8'h04
`define SMBT_RSVD_VAL 8'hFF
`define SMBT_OFFS_BCNT 8'h08
`define SMBT_BCNT_RESET 8'h08

// ----------------------------------------------------------------
// framing
// ----------------------------------------------------------------
`define SMBT_LAST_BIT 4'h7
`define SMBT_BYTE_BITS 4'h8
`define SMBT_STRAP_WAIT 2'h3

`endif

// >>> hdl/smbt_pkg.sv
/*
  Types of the SMBus indexed-block target.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smbt_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_OFFS = 4'b0010,
    ST_CNT = 4'b0011,
    ST_WDATA = 4'b0100,
    ST_ACK = 4'b0101,
    ST_TX = 4'b0110,
    ST_TXACK = 4'b0111,
    ST_TXLD = 4'b1000,
    ST_IGNORE = 4'b1001
  } smbt_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic strap;
  } smbt_bus_ev_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } smbt_reg_wr_t;

endpackage

// >>> hdl/smbt_pin_sync.sv
/*
  Pin synchroniser and bus event detector for the SMBus target.
  Assumes scl, sda and strap arrive asynchronously to ref_clk.
*/
`timescale 1ns/1ns

module smbt_pin_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic strap,
  output smbt_pkg::smbt_bus_ev_t ev
);
  import smbt_pkg::*;

  // bit 0 scl, bit 1 sda, bit 2 strap
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [1:0] old_reg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 3'h3;
      sync_reg <= 3'h3;
      old_reg <= 2'h3;
    end
    else
    begin
      meta_reg <= {strap, sda, scl};
      sync_reg <= meta_reg;
      old_reg <= sync_reg[1:0];
    end
  end

  // ----------------------------------------------------------------
  // edges and conditions seen only on second-stage copies and their one-cycle-old values
  // ----------------------------------------------------------------
  assign ev.scl = sync_reg[0];
  assign ev.sda = sync_reg[1];
  assign ev.strap = sync_reg[2];
  assign ev.scl_rise = sync_reg[0] & ~old_reg[0];
  assign ev.scl_fall = ~sync_reg[0] & old_reg[0];
  assign ev.start = sync_reg[0] & old_reg[0] & old_reg[1] & ~sync_reg[1];
  assign ev.stop = sync_reg[0] & old_reg[0] & ~old_reg[1] & sync_reg[1];

endmodule // smbt_pin_sync

// >>> hdl/smbt_target.sv
/*
  SMBus target for indexed block write and block read against a
  byte-addressed config space. Assumes the config space sits outside,
  answers reg_rdata combinationally for reg_raddr, and that the pad
  ring resolves sda from sda_low and sda_oe (open drain).
*/
// Functional notes
// - Offset byte N follows and is acknowledged
// - Count byte X follows and is acknowledged
// - Data lands at offsets N to N+X-1
// - Each written data byte acknowledged individually
// - Answer only the strap-selected target address
// - Read opens with write address and offset
// - Repeated start with read address acknowledged
// - First read byte is the byte-count register value
// - Then data from offset N onward
// - Count comes from byte-count register offset 8
// - Offset 4 reads back all ones
`timescale 1ns/1ns
`include "smbt_consts.svh"

module smbt_target (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  output logic sda_low,
  output logic sda_oe,
  input wire logic address_select_strap,
  output logic [7:0] reg_raddr,
  input wire logic [7:0] reg_rdata,
  output smbt_pkg::smbt_reg_wr_t reg_wr
);
  import smbt_pkg::*;

  smbt_bus_ev_t ev;
  smbt_state_t state_reg;
  smbt_state_t ret_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] offs_reg;
  logic [7:0] wrem_reg;
  logic [7:0] bcnt_reg;
  logic sent_cnt_reg;
  logic oe_reg;
  logic [1:0] strap_wait_reg;
  logic strap_done_reg;
  logic sel_reg;

  smbt_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl(scl),
    .sda(sda),
    .strap(address_select_strap),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [7:0] rx_byte = {shift_reg[6:0], ev.sda};
  wire [6:0] my_addr = sel_reg ? `SMBT_ADDR_STRAP1 : `SMBT_ADDR_STRAP0;
  wire addr_match = strap_done_reg && (rx_byte[7:1] == my_addr);
  wire last_rx = ev.scl_rise && (bit_reg == `SMBT_LAST_BIT);
  wire [7:0] rd_byte = (offs_reg == `SMBT_OFFS_RSVD) ? `SMBT_RSVD_VAL :
    (offs_reg == `SMBT_OFFS_BCNT) ? bcnt_reg : reg_rdata;
  // count byte first, register data afterwards
  wire [7:0] tx_byte = sent_cnt_reg ? rd_byte : bcnt_reg;
  wire tx_load = ev.scl_fall &&
    ((state_reg == ST_TXLD) ||
     (state_reg == ST_ACK && oe_reg && ret_reg == ST_TX));
  wire wr_take = last_rx && state_reg == ST_WDATA && wrem_reg != 8'h00;

  assign sda_low = 1'b0;
  assign sda_oe = oe_reg;
  assign reg_raddr = offs_reg;

  // ----------------------------------------------------------------
  // strap latch: waits for the synchroniser to fill, then freezes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_wait_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      sel_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      if (strap_wait_reg == `SMBT_STRAP_WAIT)
      begin
        strap_done_reg <= 1'b1;
        sel_reg <= ev.strap;
      end
      else
        strap_wait_reg <= strap_wait_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // transaction engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      offs_reg <= 8'h00;
      wrem_reg <= 8'h00;
      bcnt_reg <= `SMBT_BCNT_RESET;
      sent_cnt_reg <= 1'b0;
      oe_reg <= 1'b0;
      reg_wr <= '0;
    end
    else
    begin
      reg_wr.we <= 1'b0;
      if (ev.stop)
      begin
        state_reg <= ST_IDLE;
        oe_reg <= 1'b0;
      end
      else if (ev.start)
      begin
        // repeated start also lands here
        state_reg <= ST_ADDR;
        bit_reg <= 4'h0;
        oe_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_ADDR, ST_OFFS, ST_CNT, ST_WDATA:
          begin
            if (ev.scl_rise)
            begin
              shift_reg <= rx_byte;
              bit_reg <= bit_reg + 4'h1;
            end
            if (last_rx)
            begin
              bit_reg <= 4'h0;
              state_reg <= ST_ACK;
              if (state_reg == ST_ADDR)
              begin
                if (!addr_match)
                  state_reg <= ST_IGNORE;
                else if (rx_byte[0])
                begin
                  ret_reg <= ST_TX;
                  sent_cnt_reg <= 1'b0;
                end
                else
                  ret_reg <= ST_OFFS;
              end
              else if (state_reg == ST_OFFS)
              begin
                offs_reg <= rx_byte;
                ret_reg <= ST_CNT;
              end
              else if (state_reg == ST_CNT)
              begin
                wrem_reg <= rx_byte;
                ret_reg <= ST_WDATA;
              end
              else if (wr_take)
              begin
                // surplus bytes beyond X are refused
                reg_wr.we <= 1'b1;
                reg_wr.addr <= offs_reg;
                reg_wr.data <= rx_byte;
                if (offs_reg == `SMBT_OFFS_BCNT)
                  bcnt_reg <= rx_byte;
                offs_reg <= offs_reg + 8'h01;
                wrem_reg <= wrem_reg - 8'h01;
                ret_reg <= ST_WDATA;
              end
              else
                state_reg <= ST_IGNORE;
            end
          end
          ST_ACK:
          begin
            if (ev.scl_fall && !oe_reg)
              oe_reg <= 1'b1;
            else if (ev.scl_fall)
            begin
              oe_reg <= 1'b0;
              state_reg <= ret_reg;
            end
          end
          ST_TX:
          begin
            if (ev.scl_fall && bit_reg == `SMBT_BYTE_BITS)
            begin
              oe_reg <= 1'b0;
              state_reg <= ST_TXACK;
            end
            else if (ev.scl_fall)
            begin
              oe_reg <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
            end
          end
          ST_TXACK:
          begin
            if (ev.scl_rise)
              state_reg <= ev.sda ? ST_IGNORE : ST_TXLD;
          end
          ST_TXLD, ST_IDLE, ST_IGNORE:
          begin
            // idle and ignore stay off the bus until the next start or stop; ST_TXLD waits for tx_load
          end
          default:
            state_reg <= ST_IDLE;
        endcase
        if (tx_load)
        begin
          state_reg <= ST_TX;
          oe_reg <= ~tx_byte[7];
          shift_reg <= {tx_byte[6:0], 1'b0};
          bit_reg <= 4'h1;
          sent_cnt_reg <= 1'b1;
          if (sent_cnt_reg)
            offs_reg <= offs_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_addr_hit;
    state_reg == ST_ADDR && last_rx && addr_match;
  endsequence

  sequence s_ack_driven;
    state_reg == ST_ACK ##[1:1000] (oe_reg && state_reg == ST_ACK);
  endsequence

  a_addr_ack_drive: assert property (@(posedge ref_clk) disable iff (rst)
    s_addr_hit |=> s_ack_driven)
    else $error("matched address not acknowledged");

  a_addr_miss_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_ADDR && last_rx && !addr_match
      |=> state_reg == ST_IGNORE && !oe_reg)
    else $error("unmatched address was answered");

  a_ignore_off_bus: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == ST_IGNORE |-> !oe_reg)
    else $error("target drives sda while ignoring");

  a_wr_offset_step: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr.we |-> offs_reg == reg_wr.addr + 8'h01 && $past(wrem_reg) != 8'h00)
    else $error("write outside N..N+X-1");

  a_wr_byte_ack: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr.we |-> state_reg == ST_ACK && ret_reg == ST_WDATA && !oe_reg)
    else $error("written byte not headed for acknowledge");

  a_count_first: assert property (@(posedge ref_clk) disable iff (rst)
    tx_load && !sent_cnt_reg |=> oe_reg == ~bcnt_reg[7] && sent_cnt_reg)
    else $error("first read byte is not the count");

  a_rd_offset_step: assert property (@(posedge ref_clk) disable iff (rst)
    tx_load && sent_cnt_reg |=> offs_reg == $past(offs_reg) + 8'h01)
    else $error("read offset did not advance");

  a_rsvd_reads_ff: assert property (@(posedge ref_clk) disable iff (rst)
    tx_load && sent_cnt_reg && offs_reg == `SMBT_OFFS_RSVD
      |=> oe_reg == 1'b0 && shift_reg == 8'hFE)
    else $error("reserved offset not all ones");

  a_strap_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    strap_done_reg |=> strap_done_reg && $stable(sel_reg))
    else $error("strap latch changed");

  a_stop_release: assert property (@(posedge ref_clk) disable iff (rst)
    ev.stop |=> !oe_reg && state_reg == ST_IDLE)
    else $error("sda held after stop");

endmodule // smbt_target

// >>> tb/smbt_host_model.sv
/*
  SMBus host model issuing indexed block writes and reads.
  Assumes the bench resolves sda from both pull-downs with a pull-up.
*/
`timescale 1ns/1ns

module smbt_host_model (
  input wire logic ref_clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ----------------------------------------------------------------
  // bit level: each data bit scl phase is 8 clocks, above the 5 clock minimum; start and stop hold scl high for 16
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic bitx(input logic b, output logic s);
    tick(4);
    sda_low = ~b;
    tick(4);
    scl = 1'b1;
    tick(8);
    s = sda;
    scl = 1'b0;
  endtask

  // serves as start and repeated start
  task automatic start();
    tick(4);
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b0;
    tick(8);
  endtask

  task automatic xbyte(input logic [7:0] b, input logic ab,
                       output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], q[i]);
    bitx(ab, s);
    ack = ~s;
  endtask

  // ----------------------------------------------------------------
  // transactions; nsend above x breaks the count on purpose
  // ----------------------------------------------------------------
  task automatic blk_write(input logic [6:0] a, input logic [7:0] n,
    input logic [7:0] x, input int nsend, input logic [7:0] d [17],
    output logic [2:0] ha, output logic [15:0] da);
    logic [7:0] q;
    logic k;
    start();
    xbyte({a, 1'b0}, 1'b1, q, ha[2]);
    xbyte(n, 1'b1, q, ha[1]);
    xbyte(x, 1'b1, q, ha[0]);
    da = 16'h0000;
    for (int i = 0; i < nsend; i++)
    begin
      xbyte(d[i], 1'b1, q, k);
      da[i] = k;
    end
    stop();
  endtask

  task automatic blk_read(input logic [6:0] a, input logic [7:0] n,
    input int k, output logic [7:0] q [17], output logic [2:0] ha);
    logic [7:0] t;
    logic s;
    start();
    xbyte({a, 1'b0}, 1'b1, t, ha[2]);
    xbyte(n, 1'b1, t, ha[1]);
    start();
    xbyte({a, 1'b1}, 1'b1, t, ha[0]);
    // count byte first, then k data bytes; only the last is refused
    for (int i = 0; i <= k; i++) xbyte(8'hFF, i == k, q[i], s);
    stop();
  endtask
endmodule // smbt_host_model

// >>> tb/test_smbus_index_block_target.sv
/*
  Testbench of the SMBus indexed-block target with host model and a
  256-byte config space. Assumes design constants from smbt_consts.svh.
*/
`timescale 1ns/1ns
`include "smbt_consts.svh"

module test_smbus_index_block_target;
  import smbt_pkg::*;
  // offset, count, first data value, count byte expected back
  typedef struct {
    logic [7:0] n;
    logic [7:0] x;
    logic [7:0] b;
    logic [7:0] c;
  } smbt_row_t;
  logic ref_clk, rst, strap, scl, h_low, sda_low, sda_oe, sda;
  logic [7:0] reg_raddr, ev;
  int oe_cycles = 0;
  int oe_mark;
  logic [7:0] cfg [256];
  logic [7:0] d [17];
  logic [7:0] q [17];
  logic [2:0] ha;
  logic [15:0] da;
  smbt_reg_wr_t reg_wr;
  int num_errors = 0;
  int samples_checked = 0;
  // offset 4 in row 1 and offset 8 in row 2 are deliberate; row 2
  // writes 8'h04 into the byte count, so its own read and later rows expect 4
  smbt_row_t rows [4] = '{
    '{8'h00, 8'h01, 8'hA0, `SMBT_BCNT_RESET},
    '{8'h02, 8'h04, 8'h30, `SMBT_BCNT_RESET},
    '{8'h06, 8'h04, 8'h02, 8'h04},
    '{8'h10, 8'h10, 8'hC1, 8'h04}};

  // pull-up on sda: released means high
  assign sda = ~h_low & ~(sda_oe & ~sda_low);

  // config space model: one writer only, refilled while in reset
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 256; i++) cfg[i] <= 8'(i) ^ 8'h5A;
    end
    else if (reg_wr.we)
      cfg[reg_wr.addr] <= reg_wr.data;
    if (sda_oe) oe_cycles <= oe_cycles + 1;
  end

  smbt_target dut (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda(sda),
    .sda_low(sda_low), .sda_oe(sda_oe), .address_select_strap(strap),
    .reg_raddr(reg_raddr), .reg_rdata(cfg[reg_raddr]), .reg_wr(reg_wr));
  smbt_host_model host (.ref_clk(ref_clk), .scl(scl), .sda_low(h_low),
    .sda(sda));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic s);
    @(negedge ref_clk);
    rst = 1'b1;
    strap = s;
    repeat (8) @(negedge ref_clk);
    check("oe in reset", 16'h0, 16'(sda_oe));
    check("raddr in reset", 16'h0, 16'(reg_raddr));
    check("we in reset", 16'h0, 16'(reg_wr.we));
    rst = 1'b0;
    repeat (12) @(negedge ref_clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    $display("CHECK FAILED watchdog expected done seen running");
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    strap = 1'b0;
    do_reset(1'b0);
    foreach (rows[r])
    begin
      for (int i = 0; i < 17; i++) d[i] = rows[r].b + 8'(i);
      host.blk_write(`SMBT_ADDR_STRAP0, rows[r].n, rows[r].x, rows[r].x,
        d, ha, da);
      check("write hdr ack", 16'h7, 16'(ha));
      check("data ack", 16'((17'h1 << rows[r].x) - 17'h1), da);
      host.blk_read(`SMBT_ADDR_STRAP0, rows[r].n, rows[r].x, q, ha);
      check("read hdr ack", 16'h7, 16'(ha));
      check("count byte", 16'(rows[r].c), 16'(q[0]));
      for (int i = 0; i < rows[r].x; i++)
      begin
        ev = (rows[r].n + 8'(i) == `SMBT_OFFS_RSVD) ? `SMBT_RSVD_VAL : d[i];
        check("read data", 16'(ev), 16'(q[i + 1]));
      end
      check("released", 16'h0, 16'(sda_oe));
      $display("row %0d done", r);
    end
    // a byte past the count is refused and not stored
    ev = cfg[8'h21];
    host.blk_write(`SMBT_ADDR_STRAP0, 8'h20, 8'h01, 2, d, ha, da);
    check("over ack", 16'h1, da);
    check("last stored", 16'(d[0]), 16'(cfg[8'h20]));
    check("past end", 16'(ev), 16'(cfg[8'h21]));
    $display("overrun done");
    // foreign address: silent, nothing stored
    oe_mark = oe_cycles;
    ev = cfg[8'h30];
    host.blk_write(`SMBT_ADDR_STRAP1, 8'h30, 8'h01, 1, d, ha, da);
    check("foreign ack", 16'h0, 16'(ha));
    check("foreign oe", 16'h0, 16'(oe_cycles - oe_mark));
    check("foreign data", 16'(ev), 16'(cfg[8'h30]));
    $display("foreign done");
    // strap moves after latching: address stays
    strap = 1'b1;
    repeat (20) @(negedge ref_clk);
    host.blk_write(`SMBT_ADDR_STRAP0, 8'h30, 8'h01, 1, d, ha, da);
    check("frozen strap", 16'h7, 16'(ha));
    do_reset(1'b1);
    host.blk_write(`SMBT_ADDR_STRAP0, 8'h30, 8'h01, 1, d, ha, da);
    check("old address", 16'h0, 16'(ha));
    host.blk_write(`SMBT_ADDR_STRAP1, 8'h30, 8'h01, 1, d, ha, da);
    check("new address", 16'h7, 16'(ha));
    $display("strap done");
    finish_test();
  end
endmodule // test_smbus_index_block_target
